// ===== design/dbg_brkgen.v
// debug breakpoint generator with classic wishbone register slave
// Function
// - breakpoints only from final-state triggers, software
// - background command ignored in stop or wait
// - tagged channel breaks when opcode reaches execute
// - tracing session delays break until completion
// - immediate-break channel breaks at trigger always
// - end alignment: break at trigger if enabled
// - begin alignment: break when buffer fills
// - mid alignment: break after 32 more lines
// - immediate-break stops tracing; code 11 reserved
// - software trigger enters final, same timing
// - software trigger works while disarmed
// - software trigger ignored once tracing triggered
// - channel trigger ignored after software trigger
// - no breakpoints while background debug active
// - no tag entry during single-step command
// - background request beats software interrupt
// - map breakpoint to background or software interrupt
// - unserviced breakpoint re-asserted after return
// - tag travels with instruction to queue head
`timescale 1ns/1ps
`include "dbg_brkgen_consts.vh"

module dbg_brkgen
(
    input  wire        CLK,
    input  wire        RESET,
    // wishbone slave
    input  wire        CYC_I,
    input  wire        STB_I,
    input  wire        WE_I,
    input  wire [3:0]  ADR_I,
    input  wire [3:0]  SEL_I,
    input  wire [31:0] DAT_I,
    output reg  [31:0] DAT_O,
    output wire        ACK_O,
    // comparator and instruction queue
    input  wire [3:0]  CHAN_MATCH,
    input  wire        QUEUE_SHIFT,
    input  wire        EXEC_START,
    input  wire        TRACE_STORE,
    // core and background debug status
    input  wire        BDM_ENABLED,
    input  wire        BDM_ACTIVE,
    input  wire        BDM_STEP_CMD,
    input  wire        CPU_STOP_WAIT,
    input  wire        BG_CMD,
    input  wire        CORE_BDM_ACK,
    input  wire        CORE_SWI_ACK,
    // requests and state
    output wire        BRK_BDM_REQ,
    output wire        BRK_SWI_REQ,
    output wire        BG_CMD_REQ,
    output wire        TRACE_RUN,
    output wire        FINAL_STATE,
    output wire [3:0]  TAG_HIT
);

    // the block keeps little state of its own: two configuration
    // registers, the sequencer final flag, trace tracking and one
    // pending-request flop. trace lines are stored elsewhere and
    // only counted here, so the count, the tracing, final and pending flags,
    // the two request bits and the software-origin flag are what a debugger learns from this block.

    // register fields
    reg [4:0]  ctrl_q;
    reg [11:0] tcfg_q;
    reg        ack_q;
    // sequencer and trace state; waitdone_q marks a session that
    // still owes a breakpoint, so a session started by arming alone
    // never raises one when it runs out
    reg        final_q;
    reg        sworg_q;
    reg        tracing_q;
    reg        waitdone_q;
    reg [6:0]  cnt_q;
    reg        pend_q;
    reg [3:0]  tagq_q [0:2];

    // combinational views and decodes; none of them holds state,
    // so the breakpoint requests below follow pend_q and the BDM_ENABLED and BDM_ACTIVE
    // inputs through gates, and BG_CMD_REQ gates BG_CMD and CPU_STOP_WAIT with no flop; input changes reach the core at once
    wire [6:0] cnt_d;
    wire       acc;
    wire       wr;
    wire       wr_ctrl;
    wire       wr_tcfg;
    wire       arm;
    wire       brk_en;
    wire       bdm_sel;
    wire [1:0] align;
    wire       src_en;
    wire [3:0] chan_brk;
    wire [3:0] chan_tag;
    wire       sw_software_trigger_bit;
    wire [3:0] tag_ok;
    wire [3:0] hit;
    wire       chan_software_trigger_bit;
    wire       chan_imm;
    wire       software_trigger_bit;
    wire       imm;
    wire       sess_done;
    wire       brk_event;
    wire       map_bdm;
    wire       map_swi;
    integer    i;

    // true when buffer count reaches a line target
    function reached;
        input [6:0] cnt;
        input [6:0] lim;
        begin
            reached = (cnt >= lim);
        end
    endfunction

    // bus decode; one wait-free answer per request.
    // ack_q masks the access term in the answer cycle so that a
    // master still holding its strobe there is not taken twice;
    // the price is one idle cycle between back-to-back requests.
    // control writes need lane 0, since all its bits live there;
    // the trace configuration splits over lanes 0 and 1.
    assign acc     = CYC_I & STB_I & ~ack_q;
    assign wr      = acc & WE_I;
    assign wr_ctrl = wr & SEL_I[0] & (ADR_I == `DBG_OFS_CTRL);
    assign wr_tcfg = wr & (ADR_I == `DBG_OFS_TCFG);
    assign ACK_O   = ack_q;

    // field views
    assign arm      = ctrl_q[`DBG_CTRL_ARM];
    assign brk_en   = ctrl_q[`DBG_CTRL_BRKEN];
    assign bdm_sel  = ctrl_q[`DBG_CTRL_BDMSEL];
    assign align    = tcfg_q[`DBG_TCFG_ALIGN_LO +: 2];
    assign src_en   = tcfg_q[`DBG_TCFG_SRC];
    assign chan_brk = tcfg_q[`DBG_TCFG_BRK_LO +: `DBG_NCHAN];
    assign chan_tag = tcfg_q[`DBG_TCFG_TAG_LO +: `DBG_NCHAN];

    // software trigger is a write-one pulse, not stored.
    // it is not gated by arm, so software can force the final
    // state of a disarmed module; it reads back as zero because
    // the control write masks it off; only sworg_q records its use.
    assign sw_software_trigger_bit = wr_ctrl & DAT_I[`DBG_CTRL_SWTRIG];

    // tags off in background mode and during single step
    assign tag_ok = (BDM_ACTIVE | BDM_STEP_CMD) ? 4'h0 : chan_tag;

    // tag hit when tagged opcode reaches execute stage.
    // the tag rides the queue with its opcode; a flushed queue
    // simply shifts the tag out, so a branch away from the tagged
    // instruction never produces a stale hit.
    assign hit     = tagq_q[2] & {4{EXEC_START}} & tag_ok;
    assign TAG_HIT = hit;

    // untagged matches trigger at once, tagged via queue head
    assign chan_software_trigger_bit = arm & |((CHAN_MATCH & ~chan_tag) | hit);
    assign chan_imm  = |(((CHAN_MATCH & ~chan_tag) | hit) & chan_brk);

    // first trigger wins; later ones ignored in final state.
    // this covers both orders: a software trigger after a channel
    // started tracing, and a channel after a software trigger.
    // re-arming is the only way out of the final state.
    assign software_trigger_bit = ~final_q & (chan_software_trigger_bit | sw_software_trigger_bit);
    // software trigger carries no channel break option
    assign imm  = chan_software_trigger_bit & chan_imm;

    // session end per alignment; begin waits for full buffer
    assign cnt_d = cnt_q + 7'h01;
    assign sess_done = waitdone_q & TRACE_STORE & (
        ((align == `DBG_ALIGN_BEGIN) &
         reached(cnt_d, `DBG_BUF_LINES)) |
        ((align == `DBG_ALIGN_MID) &
         reached(cnt_d, `DBG_MID_LINES)));

    // a final-state event that calls for a breakpoint.
    // reserved alignment is treated like end alignment: the
    // break comes at the trigger and no tracing is started, so a
    // bad configuration can never leave a request hanging.
    assign brk_event =
        (software_trigger_bit & (imm | ~src_en | (align == `DBG_ALIGN_END) |
                 (align == `DBG_ALIGN_RSVD))) |
        sess_done;

    // mapping: background only when selected, enabled, idle.
    // the two requests are derived from one pending flop, so the
    // mapping follows the enable and activity levels as they are
    // now, not as they were when the breakpoint was raised; a
    // request masked by active background mode comes back later.
    assign map_bdm = brk_en & bdm_sel & BDM_ENABLED & ~BDM_ACTIVE;
    assign map_swi = brk_en & ~BDM_ACTIVE &
                     (~bdm_sel | ~BDM_ENABLED);
    // outputs exclusive so background wins any coincidence
    assign BRK_BDM_REQ = pend_q & map_bdm;
    assign BRK_SWI_REQ = pend_q & map_swi & ~map_bdm;

    // background command blocked in stop or wait
    assign BG_CMD_REQ = BG_CMD & ~CPU_STOP_WAIT;

    assign TRACE_RUN   = tracing_q;
    assign FINAL_STATE = final_q;

    // bus ack and read data, both from flip-flops.
    // read data is forced to zero outside the answer cycle, so a
    // master that samples late sees zero rather than old data;
    // status is a snapshot of the cycle in which the read was taken.
    always @(posedge CLK)
    begin
        if (RESET)
        begin
            ack_q <= 1'b0;
            DAT_O <= 32'h00000000;
        end
        else
        begin
            ack_q <= acc;
            DAT_O <= 32'h00000000;
            if (acc & ~WE_I)
            begin
                case (ADR_I)
                    `DBG_OFS_CTRL: DAT_O[4:0]  <= ctrl_q & 5'h19;
                    `DBG_OFS_TCFG: DAT_O[11:0] <= tcfg_q;
                    `DBG_OFS_STAT:
                    begin
                        DAT_O[`DBG_STAT_FINAL]   <= final_q;
                        DAT_O[`DBG_STAT_TRACING] <= tracing_q;
                        DAT_O[`DBG_STAT_PEND]    <= pend_q;
                        DAT_O[`DBG_STAT_SWI]     <= BRK_SWI_REQ;
                        DAT_O[`DBG_STAT_BDM]     <= BRK_BDM_REQ;
                        DAT_O[`DBG_STAT_SWORG]   <= sworg_q;
                        DAT_O[`DBG_STAT_CNT_LO +: `DBG_CNT_W] <= cnt_q;
                    end
                    default: DAT_O <= 32'h00000000;
                endcase
            end
        end
    end

    // configuration registers; arm auto-clears at session end.
    // a software write wins over the auto-clear in the same cycle,
    // because the write is what software asked for last; the
    // trigger bit is masked off so it is never stored.
    always @(posedge CLK)
    begin
        if (RESET)
        begin
            ctrl_q <= `DBG_CTRL_RST;
            tcfg_q <= `DBG_TCFG_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= DAT_I[4:0] & 5'h19;
            else if (brk_event | (software_trigger_bit & imm))
                ctrl_q[`DBG_CTRL_ARM] <= 1'b0;
            if (wr_tcfg & SEL_I[0])
                tcfg_q[7:0] <= DAT_I[7:0];
            if (wr_tcfg & SEL_I[1])
                tcfg_q[11:8] <= DAT_I[11:8];
        end
    end

    // tag queue shifts with the instruction stream.
    // a tag is attached only while armed and while tagging is
    // allowed, so a step command cannot leave a tag behind that
    // fires once the step is over.
    always @(posedge CLK)
    begin
        if (RESET)
        begin
            for (i = 0; i < `DBG_QDEPTH; i = i + 1)
                tagq_q[i] <= 4'h0;
        end
        else if (QUEUE_SHIFT)
        begin
            tagq_q[0] <= CHAN_MATCH & tag_ok & {4{arm}};
            tagq_q[1] <= tagq_q[0];
            tagq_q[2] <= tagq_q[1];
        end
    end

    // sequencer final state and trace session tracking.
    // arming clears the final, origin and count state but not pend_q,
    // and starts end or mid tracing at once when src_en is set, since those fill the buffer ahead of the trigger;
    // begin alignment waits for the trigger to start.
    // the count restarts at each trigger and stops at session end,
    // so it shows the lines stored since the trigger.
    always @(posedge CLK)
    begin
        if (RESET)
        begin
            final_q    <= 1'b0;
            sworg_q    <= 1'b0;
            tracing_q  <= 1'b0;
            waitdone_q <= 1'b0;
            cnt_q      <= 7'h00;
        end
        else if (wr_ctrl & DAT_I[`DBG_CTRL_ARM] & ~arm)
        begin
            // arming restarts the sequencer; end/mid trace at once
            final_q    <= 1'b0;
            sworg_q    <= 1'b0;
            waitdone_q <= 1'b0;
            cnt_q      <= 7'h00;
            tracing_q  <= src_en & (align != `DBG_ALIGN_BEGIN) &
                          (align != `DBG_ALIGN_RSVD);
        end
        else if (software_trigger_bit)
        begin
            final_q <= 1'b1;
            sworg_q <= ~chan_software_trigger_bit;
            cnt_q   <= 7'h00;
            if (imm | ~src_en | (align == `DBG_ALIGN_END) |
                (align == `DBG_ALIGN_RSVD))
            begin
                tracing_q  <= 1'b0;
                waitdone_q <= 1'b0;
            end
            else
            begin
                // begin starts here, mid keeps running
                tracing_q  <= 1'b1;
                waitdone_q <= 1'b1;
            end
        end
        else if (sess_done)
        begin
            tracing_q  <= 1'b0;
            waitdone_q <= 1'b0;
            cnt_q      <= cnt_d;
        end
        else if (waitdone_q & TRACE_STORE)
            cnt_q <= cnt_d;
    end

    // pending request held to ack; set beats ack in same cycle.
    // the ack is honoured only for the request that is shown, so
    // an ack from the wrong service path cannot drop a request;
    // with breakpoints disabled no request is ever recorded.
    always @(posedge CLK)
    begin
        if (RESET)
            pend_q <= 1'b0;
        else if (brk_event & brk_en)
            pend_q <= 1'b1;
        else if ((CORE_BDM_ACK & BRK_BDM_REQ) |
                 (CORE_SWI_ACK & BRK_SWI_REQ))
            pend_q <= 1'b0;
    end

endmodule // dbg_brkgen

// ===== design/dbg_brkgen_consts.vh
// constants for the debug breakpoint generator
`ifndef DBG_BRKGEN_CONSTS_VH
`define DBG_BRKGEN_CONSTS_VH

// register byte offsets (low address bits used for decode)
`define DBG_ADDR_W        4
`define DBG_OFS_CTRL      4'h0
`define DBG_OFS_TCFG      4'h4
`define DBG_OFS_STAT      4'h8

// debug_control_one fields
`define DBG_CTRL_ARM      0
`define DBG_CTRL_SWTRIG   1
`define DBG_CTRL_BRKEN    3
`define DBG_CTRL_BDMSEL   4

// trace configuration fields
`define DBG_TCFG_ALIGN_LO 0
`define DBG_TCFG_SRC      2
`define DBG_TCFG_BRK_LO   4
`define DBG_TCFG_TAG_LO   8

// status fields
`define DBG_STAT_FINAL    0
`define DBG_STAT_TRACING  1
`define DBG_STAT_PEND     2
`define DBG_STAT_SWI      3
`define DBG_STAT_BDM      4
`define DBG_STAT_SWORG    5
`define DBG_STAT_CNT_LO   8

// trigger alignment codes
`define DBG_ALIGN_END     2'h0
`define DBG_ALIGN_BEGIN   2'h1
`define DBG_ALIGN_MID     2'h2
`define DBG_ALIGN_RSVD    2'h3

// sizes and counts
`define DBG_NCHAN         4
`define DBG_QDEPTH        3
`define DBG_CNT_W         7
`define DBG_MID_LINES     7'h20
`define DBG_BUF_LINES     7'h40

// reset values
`define DBG_CTRL_RST      5'h00
`define DBG_TCFG_RST      12'h000

`endif

// ===== verif/dbg_brkgen_asserts.sv
// port checker for the breakpoint generator
`timescale 1ns/1ps
module dbg_brkgen_asserts
(
    input wire        CLK,
    input wire        RESET,
    input wire        CYC_I,
    input wire        STB_I,
    input wire        ACK_O,
    input wire [31:0] DAT_O,
    input wire        BDM_ACTIVE,
    input wire        BG_CMD,
    input wire        CPU_STOP_WAIT,
    input wire        CORE_BDM_ACK,
    input wire        CORE_SWI_ACK,
    input wire        BRK_BDM_REQ,
    input wire        BRK_SWI_REQ,
    input wire        BG_CMD_REQ,
    input wire        FINAL_STATE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    // any breakpoint request toward the core or acknowledge from it
    wire req  = BRK_BDM_REQ | BRK_SWI_REQ;
    wire cack = CORE_BDM_ACK | CORE_SWI_ACK;
    sequence bus_take; CYC_I && STB_I && !ACK_O; endsequence
    sequence bus_ans; ACK_O ##1 !ACK_O; endsequence
    bus_ack_a: assert property (bus_take |=> bus_ans)
        else $error("bus answer missing or too long");
    ack_cause_a: assert property (ACK_O |-> $past(CYC_I && STB_I))
        else $error("ack without request");
    dat_idle_a: assert property (!ACK_O |-> DAT_O == 32'h0)
        else $error("read data outside ack");
    req_excl_a: assert property (!(BRK_BDM_REQ && BRK_SWI_REQ))
        else $error("both requests at once");
    bdm_mask_a: assert property (BDM_ACTIVE |-> !req)
        else $error("request while debug active");
    bg_gate_a: assert property (BG_CMD_REQ == (BG_CMD && !CPU_STOP_WAIT))
        else $error("background command gating wrong");
    req_hold_a: assert property (req && !cack && !BDM_ACTIVE |=> req)
        else $error("request dropped before ack");
    req_final_a: assert property ($rose(req) |-> FINAL_STATE)
        else $error("request outside final state");
    ack_drop_a: assert property (cack |=> !req)
        else $error("request kept after ack");
endmodule // dbg_brkgen_asserts
bind dbg_brkgen dbg_brkgen_asserts chk_u (.*);

// ===== verif/dbg_core_model.sv
// core model that services breakpoint requests
`timescale 1ns/1ps
module dbg_core_model
(
    input  wire CLK,
    input  wire RESET,
    input  wire BRK_BDM_REQ,
    input  wire BRK_SWI_REQ,
    input  wire SLOW,
    output reg  CORE_BDM_ACK,
    output reg  CORE_SWI_ACK
);
    reg [3:0] wait_q;
    // answer 2 or 9 cycles after the request; a slow core tests held requests
    always @(posedge CLK)
    begin
        CORE_BDM_ACK <= 1'b0;
        CORE_SWI_ACK <= 1'b0;
        if (RESET || !(BRK_BDM_REQ || BRK_SWI_REQ) || CORE_BDM_ACK
            || CORE_SWI_ACK)
            wait_q <= 4'h0;
        else if (wait_q == (SLOW ? 4'h8 : 4'h1))
        begin
            CORE_BDM_ACK <= BRK_BDM_REQ;
            CORE_SWI_ACK <= BRK_SWI_REQ; // bench re-arms after
            wait_q       <= 4'h0;
        end
        else
            wait_q <= wait_q + 4'h1;
    end
endmodule // dbg_core_model

// ===== verif/test_dbg_brkgen.sv
// self-checking bench for the breakpoint generator
`timescale 1ns/1ps
`include "dbg_brkgen_consts.vh"
module test_dbg_brkgen;
    logic        CLK, RESET, CYC_I, STB_I, WE_I, TRACE_STORE, SLOW;
    logic        QUEUE_SHIFT, EXEC_START, BDM_STEP_CMD, BG_CMD;
    logic        BDM_ENABLED, BDM_ACTIVE, CPU_STOP_WAIT;
    logic [3:0]  ADR_I, SEL_I, CHAN_MATCH;
    logic [31:0] DAT_I, rd;
    wire  [31:0] DAT_O;
    wire  [3:0]  TAG_HIT;
    wire         ACK_O, BRK_BDM_REQ, BRK_SWI_REQ, BG_CMD_REQ, TRACE_RUN;
    wire         FINAL_STATE, CORE_BDM_ACK, CORE_SWI_ACK;
    wire  [31:0] reqs = {30'h0, BRK_BDM_REQ, BRK_SWI_REQ};
    int          n_mismatch = 0;
    int          n_checks = 0;
    dbg_brkgen dut_u (.*);
    dbg_core_model core_u (.*);
    initial
    begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    task chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wrap_up;
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one classic cycle; data taken at the ack edge only
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        {CYC_I, STB_I, WE_I, ADR_I, DAT_I} <= {2'b11, w, a, d};
        n = 0;
        do @(posedge CLK); while (ACK_O !== 1'b1 && ++n < 20);
        rd = DAT_O;
        chk("ack", {31'h0, ACK_O}, 1);
        {CYC_I, STB_I, WE_I} <= 3'b000;
    endtask
    // disarm first so the arm write clears the final state
    task setup(input logic [11:0] t, input logic [4:0] c);
        wb(1'b1, `DBG_OFS_CTRL, 32'h0);
        wb(1'b1, `DBG_OFS_TCFG, {20'h0, t});
        wb(1'b1, `DBG_OFS_CTRL, {27'h0, c});
    endtask
    task pulse(input logic [3:0] m);
        @(posedge CLK);
        CHAN_MATCH <= m;
        @(posedge CLK);
        CHAN_MATCH <= 4'h0;
        #1;
    endtask
    task drain;
        int n;
        n = 0;
        while (reqs !== 32'h0 && n++ < 40)
            @(posedge CLK);
        #1 chk("drained", reqs, 0);
    endtask
    // n trace lines; the request must follow the last one exactly
    task stores(input int n);
        @(posedge CLK);
        TRACE_STORE <= 1'b1;
        repeat (n - 1) @(posedge CLK);
        #1 chk("early", reqs, 0);
        @(posedge CLK);
        TRACE_STORE <= 1'b0;
        #1 chk("done", reqs, 1);
    endtask
    task t_regs;
        wb(1'b0, `DBG_OFS_CTRL, 0);
        chk("ctrl", rd, 0);
        wb(1'b0, `DBG_OFS_STAT, 0);
        chk("stat", rd, 0);
        wb(1'b0, 4'hc, 0);
        chk("unmapped", rd, 0);
        wb(1'b1, `DBG_OFS_TCFG, 32'hfff);
        wb(1'b0, `DBG_OFS_TCFG, 0);
        chk("tcfg", rd, 32'hfff);
    endtask
    task t_map;
        logic [31:0] c;
        logic [7:0]  e;
        c = 32'h11191909;
        e = 8'b00100101;
        for (int i = 0; i < 4; i++)
        begin
            BDM_ENABLED <= i[1];
            setup(12'h004, c[i*8 +: 5]);
            pulse(4'h1);
            chk("map", reqs, {30'h0, e[i*2 +: 2]});
            drain;
        end
    endtask
    task t_cnt;
        setup(12'h005, 5'h09);
        pulse(4'h2);
        chk("tracing", {31'h0, TRACE_RUN}, 1);
        stores(64);
        drain;
        setup(12'h006, 5'h09);
        pulse(4'h4);
        wb(1'b1, `DBG_OFS_CTRL, 32'h0a);
        stores(32);
        drain;
        setup(12'h007, 5'h09);
        pulse(4'h1);
        chk("rsvd", reqs, 1);
        chk("rsvd run", {31'h0, TRACE_RUN}, 0);
        drain;
    endtask
    task t_tag;
        setup(12'h104, 5'h09);
        @(posedge CLK);
        {CHAN_MATCH, QUEUE_SHIFT} <= 5'h03;
        @(posedge CLK);
        CHAN_MATCH <= 4'h0;
        @(posedge CLK);
        @(posedge CLK);
        {QUEUE_SHIFT, EXEC_START} <= 2'b01;
        #1 chk("tag", {28'h0, TAG_HIT}, 1);
        chk("tag early", reqs, 0);
        @(posedge CLK);
        EXEC_START <= 1'b0;
        #1 chk("tag brk", reqs, 1);
        drain;
        @(posedge CLK);
        {BDM_STEP_CMD, EXEC_START} <= 2'b11;
        #1 chk("step", {28'h0, TAG_HIT}, 0);
        @(posedge CLK);
        {BDM_STEP_CMD, EXEC_START} <= 2'b00;
    endtask
    task t_imm;
        SLOW <= 1'b1;
        setup(12'h016, 5'h09);
        chk("running", {31'h0, TRACE_RUN}, 1);
        pulse(4'h1);
        chk("imm", reqs, 1);
        chk("stopped", {31'h0, TRACE_RUN}, 0);
        drain;
        SLOW <= 1'b0;
    endtask
    task t_sw;
        setup(12'h005, 5'h09);
        wb(1'b1, `DBG_OFS_CTRL, 32'h08);
        wb(1'b1, `DBG_OFS_CTRL, 32'h0a);
        pulse(4'h1);
        chk("final", {31'h0, FINAL_STATE}, 1);
        stores(64);
        drain;
    endtask
    task t_bdm;
        {BG_CMD, CPU_STOP_WAIT, BDM_ACTIVE} <= 3'b111;
        setup(12'h004, 5'h09);
        pulse(4'h1);
        chk("masked", reqs, 0);
        chk("bgstop", {31'h0, BG_CMD_REQ}, 0);
        @(posedge CLK);
        {CPU_STOP_WAIT, BDM_ACTIVE} <= 2'b00;
        #1 chk("reassert", reqs, 1);
        chk("bgrun", {31'h0, BG_CMD_REQ}, 1);
        drain;
    endtask
    initial
    begin
        {RESET, CYC_I, STB_I, WE_I, TRACE_STORE, SLOW} = 6'b100000;
        {QUEUE_SHIFT, EXEC_START, BDM_STEP_CMD, BG_CMD} = 4'h0;
        {BDM_ENABLED, BDM_ACTIVE, CPU_STOP_WAIT} = 3'b000;
        {ADR_I, SEL_I, CHAN_MATCH, DAT_I} = {8'h0f, 4'h0, 32'h0};
        repeat (6) @(posedge CLK);
        RESET <= 1'b0;
        t_regs;
        t_map;
        t_cnt;
        t_imm;
        t_sw;
        t_tag;
        t_bdm;
        wrap_up;
    end
    // whole run needs well under 2000 cycles
    initial
    begin
        #100000;
        n_mismatch++;
        $display("[FAIL] watchdog expected done seen hang");
        wrap_up;
    end
endmodule // test_dbg_brkgen
